// [rtl/frws_map.vh]
// register map, field positions and constants for the row write sequencer
`ifndef FRWS_MAP_VH
`define FRWS_MAP_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define FRWS_OFF_ADDR_LOW   8'h00
`define FRWS_OFF_ADDR_HIGH  8'h04
`define FRWS_OFF_DATA_LOW   8'h08
`define FRWS_OFF_DATA_HIGH  8'h0c
`define FRWS_OFF_CONTROL    8'h10
`define FRWS_OFF_KEY        8'h14
`define FRWS_OFF_STATUS     8'h18

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define FRWS_CTL_FIXED      7
`define FRWS_CTL_CONFIG_SPACE_SELECT       6
`define FRWS_CTL_LATCH_LOAD_ONLY       5
`define FRWS_CTL_FREE       4
`define FRWS_CTL_ERR        3
`define FRWS_CTL_PROGRAM_ERASE_ENABLE       2
`define FRWS_CTL_WR         1

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define FRWS_STS_BUSY       0
`define FRWS_STS_STALL      1
`define FRWS_STS_ARMED      2

// ---------------------------------------------------------------
// unlock keys, latches, timing
// ---------------------------------------------------------------
`define FRWS_KEY_FIRST      8'h55
`define FRWS_KEY_SECOND     8'haa
`define FRWS_KEY_NONE       2'h0
`define FRWS_KEY_HALF       2'h1
`define FRWS_KEY_ARMED      2'h2
`define FRWS_BLANK          14'h3fff
`define FRWS_LATCHES        5'h10
`define FRWS_LAST_NOP       5'h01
`define FRWS_FIRST_NOP      5'h00
`define FRWS_CNT_STEP       5'h01

`endif

// [rtl/frws_latch_bank.v]
// sixteen 14-bit write latches with one write port, registered read and clear-to-blank
`timescale 1ns/100ps
`include "frws_map.vh"

module frws_latch_bank (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        we,
    input  wire [3:0]  widx,
    input  wire [13:0] wdata,
    input  wire        clr,
    input  wire        re,
    input  wire [3:0]  ridx,
    output reg  [13:0] rdata_reg
);

    wire [223:0] words;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : lat
            reg [13:0] word_reg;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    word_reg <= `FRWS_BLANK;
                end else if (clr) begin
                    word_reg <= `FRWS_BLANK;
                end else if (we && widx == g) begin
                    word_reg <= wdata;
                end
            end
            assign words[g*14 +: 14] = word_reg;
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `FRWS_BLANK;
        end else if (re) begin
            rdata_reg <= words[ridx*14 +: 14];
        end
    end

endmodule

// [rtl/frws_sequencer.v]
// row write sequencer: ahb-lite registers, unlock guard, latch loading and row commit
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "frws_map.vh"

module frws_sequencer (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        flash_done,
    output reg  [9:0]  flash_row_addr,
    output reg         flash_wr_en,
    output reg  [3:0]  flash_wr_idx,
    output reg  [13:0] flash_wr_data,
    output reg         flash_prog_start,
    output reg         flash_erase_start,
    output reg         cpu_nop,
    output reg         cpu_stall
);

    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam S_IDLE   = 3'd0;
    localparam S_NOPS   = 3'd1;
    localparam S_STREAM = 3'd2;
    localparam S_START  = 3'd3;
    localparam S_WAIT   = 3'd4;
    // unused codes fall back to idle through the default branch

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg        wr_pend_reg;
    reg [7:0]  wr_addr_reg;
    reg [7:0]  addr_low_reg,  addr_low_next;
    reg [6:0]  addr_high_reg, addr_high_next;
    reg [7:0]  data_low_reg,  data_low_next;
    reg [5:0]  data_high_reg, data_high_next;
    reg        config_space_select_reg,      config_space_select_next;
    reg        latch_load_only_reg,      latch_load_only_next;
    reg        free_reg,      free_next;
    reg        err_reg,       err_next;
    reg        program_erase_enable_reg,      program_erase_enable_next;
    reg        wr_reg,        wr_next;
    reg [1:0]  key_reg,       key_next;
    reg [2:0]  state_reg,     state_next;
    reg [4:0]  cnt_reg,       cnt_next;
    reg        erase_op_reg,  erase_op_next;
    reg        long_op_reg,   long_op_next;
    reg        rdv_reg;
    reg [3:0]  rdi_reg;
    reg [31:0] rd_mux;

    wire [7:0]  wd      = hwdata[7:0];
    wire        accept  = hsel & hready & htrans[1];
    wire        ctl_w   = wr_pend_reg & hit(wr_addr_reg, `FRWS_OFF_CONTROL);
    wire        key_w   = wr_pend_reg & hit(wr_addr_reg, `FRWS_OFF_KEY);
    // trigger is a control write carrying the wr bit while idle
    wire        trig    = ctl_w & wd[`FRWS_CTL_WR] & ~wr_reg;
    // needs both keys with no other write in between, enable set and config select clear
    wire        go      = trig & (key_reg == `FRWS_KEY_ARMED)
                          & wd[`FRWS_CTL_PROGRAM_ERASE_ENABLE]
                          & ~wd[`FRWS_CTL_CONFIG_SPACE_SELECT];
    wire        bad_try = trig & ~go;
    wire        ld_latch = go & ~wd[`FRWS_CTL_FREE];
    wire        finish  = (state_reg == S_WAIT) & flash_done;
    wire        ld_done = (state_reg == S_NOPS) & (cnt_reg == `FRWS_LAST_NOP) & ~long_op_reg;
    wire        rd_en   = (state_reg == S_STREAM) & (cnt_reg < `FRWS_LATCHES);
    wire [13:0] lat_rdata;

    // ---------------------------------------------------------------
    // per-register write strobes
    // ---------------------------------------------------------------
    // address and data writes are refused while busy so the row cannot move
    wire        idle_w   = wr_pend_reg & ~wr_reg;
    wire        al_w     = idle_w & hit(wr_addr_reg, `FRWS_OFF_ADDR_LOW);
    wire        ah_w     = idle_w & hit(wr_addr_reg, `FRWS_OFF_ADDR_HIGH);
    wire        dl_w     = idle_w & hit(wr_addr_reg, `FRWS_OFF_DATA_LOW);
    wire        dh_w     = idle_w & hit(wr_addr_reg, `FRWS_OFF_DATA_HIGH);
    wire [13:0] lat_word = {data_high_reg, data_low_reg};

    // ---------------------------------------------------------------
    // latch bank
    // ---------------------------------------------------------------
    // cleared when a program or erase ends, never after a load-only trigger
    frws_latch_bank frws_latch_bank_i (
        .clk       (hclk),
        .rst_n     (hresetn),
        .we        (ld_latch),
        .widx      (addr_low_reg[3:0]),
        .wdata     (lat_word),
        .clr       (finish),
        .re        (rd_en),
        .ridx      (cnt_reg[3:0]),
        .rdata_reg (lat_rdata)
    );

    // ---------------------------------------------------------------
    // register next values
    // ---------------------------------------------------------------
    always @* begin
        addr_low_next  = addr_low_reg;
        addr_high_next = addr_high_reg;
        data_low_next  = data_low_reg;
        data_high_next = data_high_reg;
        config_space_select_next      = config_space_select_reg;
        latch_load_only_next      = latch_load_only_reg;
        free_next      = free_reg;
        program_erase_enable_next      = program_erase_enable_reg;
        wr_next        = wr_reg;
        err_next       = err_reg;
        key_next       = key_reg;
        // address and data are frozen while an operation runs so the row cannot move
        if (wr_pend_reg && !wr_reg) begin
            if (al_w) begin
                addr_low_next = wd;
            end
            if (ah_w) begin
                addr_high_next = wd[6:0];
            end
            if (dl_w) begin
                data_low_next = wd;
            end
            if (dh_w) begin
                data_high_next = wd[5:0];
            end
            if (ctl_w) begin
                config_space_select_next = wd[`FRWS_CTL_CONFIG_SPACE_SELECT];
                latch_load_only_next = wd[`FRWS_CTL_LATCH_LOAD_ONLY];
                free_next = wd[`FRWS_CTL_FREE];
                program_erase_enable_next = wd[`FRWS_CTL_PROGRAM_ERASE_ENABLE];
                err_next  = wd[`FRWS_CTL_ERR];
            end
        end
        // any write other than the next key breaks the unlock chain
        // reads leave the chain alone
        if (key_w) begin
            if (wd == `FRWS_KEY_FIRST) begin
                key_next = `FRWS_KEY_HALF;
            end else if (wd == `FRWS_KEY_SECOND && key_reg == `FRWS_KEY_HALF) begin
                key_next = `FRWS_KEY_ARMED;
            end else begin
                key_next = `FRWS_KEY_NONE;
            end
        end else if (wr_pend_reg) begin
            key_next = `FRWS_KEY_NONE;
        end
        // a refused trigger never sets the trigger bit
        if (go) begin
            wr_next = 1'b1;
        end
        if (finish || ld_done) begin
            wr_next = 1'b0;
            if (erase_op_reg) begin
                free_next = 1'b0;
            end
        end
        // set wins over a software clear in the same cycle
        if (bad_try) begin
            err_next = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // sequence state machine
    // ---------------------------------------------------------------
    always @* begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        erase_op_next = erase_op_reg;
        long_op_next  = long_op_reg;
        case (state_reg)
            S_IDLE: begin
                if (go) begin
                    state_next    = S_NOPS;
                    cnt_next      = `FRWS_FIRST_NOP;
                    erase_op_next = wd[`FRWS_CTL_FREE];
                    long_op_next  = wd[`FRWS_CTL_FREE] | ~wd[`FRWS_CTL_LATCH_LOAD_ONLY];
                end
            end
            S_NOPS: begin
                // two forced no-op cycles, counted first and last
                cnt_next = cnt_reg + `FRWS_CNT_STEP;
                if (cnt_reg == `FRWS_LAST_NOP) begin
                    cnt_next = `FRWS_FIRST_NOP;
                    if (!long_op_reg) begin
                        state_next = S_IDLE;
                    end else if (erase_op_reg) begin
                        state_next = S_START;
                    end else begin
                        state_next = S_STREAM;
                    end
                end
            end
            S_STREAM: begin
                // all sixteen latches of the one row go out, no more
                // the bank read is registered, so words leave two cycles after their count
                if (cnt_reg == `FRWS_LATCHES) begin
                    state_next = S_START;
                end else begin
                    cnt_next = cnt_reg + `FRWS_CNT_STEP;
                end
            end
            S_START: begin
                state_next = S_WAIT;
            end
            S_WAIT: begin
                // done outside this state is ignored so a stray pulse cannot end a run
                if (flash_done) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // read mux, fed from next values so a read right after a write sees it
    // ---------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `FRWS_OFF_ADDR_LOW:  rd_mux[7:0] = addr_low_next;
            `FRWS_OFF_ADDR_HIGH: rd_mux[7:0] = {1'b1, addr_high_next};
            `FRWS_OFF_DATA_LOW:  rd_mux[7:0] = data_low_next;
            `FRWS_OFF_DATA_HIGH: rd_mux[7:0] = {2'b00, data_high_next};
            `FRWS_OFF_CONTROL:   rd_mux[7:0] = {1'b1, config_space_select_next, latch_load_only_next, free_next,
                                                err_next, program_erase_enable_next, wr_next, 1'b0};
            `FRWS_OFF_STATUS: begin
                rd_mux[`FRWS_STS_BUSY]  = wr_next;
                rd_mux[`FRWS_STS_STALL] = long_op_next & (state_next != S_IDLE);
                rd_mux[`FRWS_STS_ARMED] = (key_next == `FRWS_KEY_ARMED);
            end
            // the key register is write only and reads zero through the default
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------------------------
    // bus and control flops
    // ---------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
            hrdata        <= 32'h0000_0000;
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            addr_low_reg  <= 8'h00;
            addr_high_reg <= 7'h00;
            data_low_reg  <= 8'h00;
            data_high_reg <= 6'h00;
            config_space_select_reg      <= 1'b0;
            latch_load_only_reg      <= 1'b0;
            free_reg      <= 1'b0;
            err_reg       <= 1'b0;
            program_erase_enable_reg      <= 1'b0;
            wr_reg        <= 1'b0;
            key_reg       <= `FRWS_KEY_NONE;
            state_reg     <= S_IDLE;
            cnt_reg       <= 5'h00;
            erase_op_reg  <= 1'b0;
            long_op_reg   <= 1'b0;
        end else begin
            wr_pend_reg   <= accept & hwrite;
            wr_addr_reg   <= haddr[7:0];
            if (accept && !hwrite) begin
                hrdata <= rd_mux;
            end
            // zero wait states, so the bus never stalls and the answer is always okay
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            addr_low_reg  <= addr_low_next;
            addr_high_reg <= addr_high_next;
            data_low_reg  <= data_low_next;
            data_high_reg <= data_high_next;
            config_space_select_reg      <= config_space_select_next;
            latch_load_only_reg      <= latch_load_only_next;
            free_reg      <= free_next;
            err_reg       <= err_next;
            program_erase_enable_reg      <= program_erase_enable_next;
            wr_reg        <= wr_next;
            key_reg       <= key_next;
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            erase_op_reg  <= erase_op_next;
            long_op_reg   <= long_op_next;
        end
    end

    // ---------------------------------------------------------------
    // array and processor side outputs
    // ---------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdv_reg           <= 1'b0;
            rdi_reg           <= 4'h0;
            flash_row_addr    <= 10'h000;
            flash_wr_en       <= 1'b0;
            flash_wr_idx      <= 4'h0;
            flash_wr_data     <= `FRWS_BLANK;
            flash_prog_start  <= 1'b0;
            flash_erase_start <= 1'b0;
            cpu_nop           <= 1'b0;
            cpu_stall         <= 1'b0;
        end else begin
            // read data lags the index by one cycle
            rdv_reg           <= rd_en;
            rdi_reg           <= cnt_reg[3:0];
            // the row is taken at the trigger; later address writes cannot steer it
            if (go) begin
                flash_row_addr <= {addr_high_reg, addr_low_reg[7:5]};
            end
            flash_wr_en       <= rdv_reg;
            flash_wr_idx      <= rdi_reg;
            flash_wr_data     <= lat_rdata;
            // commit never pulses erase; erase is its own single-row command
            flash_prog_start  <= (state_reg == S_START) & ~erase_op_reg;
            flash_erase_start <= (state_reg == S_START) & erase_op_reg;
            cpu_nop           <= go | ((state_reg == S_NOPS)
                                       & (cnt_reg == `FRWS_FIRST_NOP));
            // stall follows the next state so it rises together with the first no-op
            cpu_stall         <= long_op_next & (state_next != S_IDLE);
        end
    end

endmodule

// [testbench/frws_asserts.sv]
// concurrent checks on the row write sequencer ports
`timescale 1ns/100ps

module frws_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        flash_done,
    input wire logic [9:0]  flash_row_addr,
    input wire logic        flash_wr_en,
    input wire logic [3:0]  flash_wr_idx,
    input wire logic        flash_prog_start,
    input wire logic        flash_erase_start,
    input wire logic        cpu_nop,
    input wire logic        cpu_stall
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ---------------------------------------------------------------
    // processor hold-off
    // ---------------------------------------------------------------
    nop_pair_a: assert property (
        $rose(cpu_nop) |=> cpu_nop ##1 !cpu_nop)
        else $error("forced no-op window is not two cycles");
    stall_nop_a: assert property (
        $rose(cpu_stall) |-> $rose(cpu_nop))
        else $error("stall began without the forced no-ops");
    // the done pulse and the cycle after it may both end the stall
    stall_hold_a: assert property (
        cpu_stall && !flash_done && !$past(flash_done) |=> cpu_stall)
        else $error("stall dropped before the array finished");
    stall_release_a: assert property (
        cpu_stall && flash_done |-> ##[1:2] !cpu_stall)
        else $error("stall held after the array finished");

    // ---------------------------------------------------------------
    // row commit
    // ---------------------------------------------------------------
    stream_first_a: assert property (
        $rose(cpu_stall) |->
            (##3 flash_erase_start) or (##4 (flash_wr_en && flash_wr_idx == 4'h0)))
        else $error("neither erase nor latch stream began on time");
    stream_step_a: assert property (
        flash_wr_en && flash_wr_idx != 4'hf |=>
            flash_wr_en && flash_wr_idx == $past(flash_wr_idx) + 4'h1)
        else $error("latch stream skipped or stopped early");
    commit_a: assert property (
        flash_prog_start |-> !flash_erase_start && cpu_stall
            && $past(flash_wr_en) && $past(flash_wr_idx) == 4'hf)
        else $error("program start without a full stream or with erase");
    row_hold_a: assert property (
        cpu_stall && $past(cpu_stall) |-> $stable(flash_row_addr))
        else $error("row address moved during an operation");
endmodule

// [testbench/test_flash_row_write_sequencer.sv]
// self-checking bench for the row write sequencer
`timescale 1ns/100ps
`include "frws_map.vh"

`define CHK(w, e, s) \
    begin \
        num_checks = num_checks + 1; \
        if ((s) !== (e)) begin \
            miscompares = miscompares + 1; \
            $display("BAD %s expected %h seen %h", w, e, s); \
        end \
    end

module test_flash_row_write_sequencer;
    typedef struct { logic [7:0] off; logic [7:0] wd; logic [31:0] ex; } frws_row_t;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        flash_done;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire  [9:0]  flash_row_addr;
    wire         flash_wr_en;
    wire  [3:0]  flash_wr_idx;
    wire  [13:0] flash_wr_data;
    wire         flash_prog_start;
    wire         flash_erase_start;
    wire         cpu_nop;
    wire         cpu_stall;
    int          miscompares = 0;
    int          num_checks = 0;
    int          n_wr = 0, n_prog = 0, n_erase = 0, n_nop = 0;
    int          b_wr, b_prog, b_erase, b_nop;
    logic [31:0] rd;
    logic [13:0] ex14;
    logic [13:0] got [0:15];
    frws_row_t   rows [0:7];

    frws_sequencer frws_sequencer_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_done(flash_done),
        .flash_row_addr(flash_row_addr), .flash_wr_en(flash_wr_en),
        .flash_wr_idx(flash_wr_idx), .flash_wr_data(flash_wr_data),
        .flash_prog_start(flash_prog_start), .flash_erase_start(flash_erase_start),
        .cpu_nop(cpu_nop), .cpu_stall(cpu_stall)
    );

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // the array side is observed, not modelled: streamed words land here
    always @(posedge hclk) begin
        if (flash_wr_en) begin
            got[flash_wr_idx] <= flash_wr_data;
            n_wr <= n_wr + 1;
        end
        if (flash_prog_start) n_prog <= n_prog + 1;
        if (flash_erase_start) n_erase <= n_erase + 1;
        if (cpu_nop) n_nop <= n_nop + 1;
    end

    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n = n + 1;
        end
        if (n >= 50) begin
            miscompares = miscompares + 1;
            $display("BAD hreadyout expected 1 seen %b", hreadyout);
            end_sim;
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] off, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, off};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        wait_ready;
        rd = hrdata;
    endtask

    task automatic chk_rd(input logic [7:0] off, input logic [31:0] ex);
        ahb(1'b0, off, 8'h00);
        `CHK("register read", ex, rd)
        `CHK("response", 1'b0, hresp)
    endtask

    task automatic unlock(input logic [7:0] ctl);
        ahb(1'b1, `FRWS_OFF_KEY, `FRWS_KEY_FIRST);
        ahb(1'b1, `FRWS_OFF_KEY, `FRWS_KEY_SECOND);
        ahb(1'b1, `FRWS_OFF_CONTROL, ctl);
    endtask

    task automatic snap;
        b_wr = n_wr;
        b_prog = n_prog;
        b_erase = n_erase;
        b_nop = n_nop;
    endtask

    // program start lands 21 cycles after the trigger, so 30 leaves margin
    task automatic finish_op;
        chk_rd(`FRWS_OFF_STATUS, 32'h03);
        repeat (28) @(posedge hclk);
        flash_done <= 1'b1;
        @(posedge hclk);
        flash_done <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        flash_done = 1'b0;
        rows = '{'{8'h00, 8'ha5, 32'ha5}, '{8'h04, 8'h7f, 32'hff}, '{8'h04, 8'h00, 32'h80},
                 '{8'h08, 8'h3c, 32'h3c}, '{8'h0c, 8'hff, 32'h3f}, '{8'h14, 8'h55, 32'h00},
                 '{8'h1c, 8'hff, 32'h00}, '{8'h10, 8'h24, 32'ha4}};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd(`FRWS_OFF_CONTROL, 32'h80);
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].off, rows[i].wd);
            chk_rd(rows[i].off, rows[i].ex);
        end
        $display("test registers done");
        ahb(1'b1, `FRWS_OFF_ADDR_HIGH, 8'h03);
        ahb(1'b1, `FRWS_OFF_ADDR_LOW, 8'h42);
        ahb(1'b1, `FRWS_OFF_DATA_HIGH, 8'h12);
        ahb(1'b1, `FRWS_OFF_DATA_LOW, 8'h34);
        snap;
        unlock(8'h26);
        repeat (6) @(posedge hclk);
        `CHK("no-op cycles", b_nop + 2, n_nop)
        `CHK("load-only array traffic", b_prog + b_wr, n_prog + n_wr)
        chk_rd(`FRWS_OFF_CONTROL, 32'ha4);
        ahb(1'b1, `FRWS_OFF_ADDR_LOW, 8'h43);
        ahb(1'b1, `FRWS_OFF_DATA_HIGH, 8'h2b);
        ahb(1'b1, `FRWS_OFF_DATA_LOW, 8'hcd);
        unlock(8'h26);
        repeat (6) @(posedge hclk);
        $display("test latch loads done");
        // interrupted unlock, enable clear, config select: all refused
        for (int i = 0; i < 3; i++) begin
            snap;
            if (i == 0) begin
                ahb(1'b1, `FRWS_OFF_KEY, `FRWS_KEY_FIRST);
                ahb(1'b1, `FRWS_OFF_DATA_LOW, 8'h00);
                ahb(1'b1, `FRWS_OFF_KEY, `FRWS_KEY_SECOND);
                ahb(1'b1, `FRWS_OFF_CONTROL, 8'h26);
            end else begin
                unlock(i == 1 ? 8'h22 : 8'h66);
            end
            repeat (6) @(posedge hclk);
            `CHK("refused trigger no-ops", b_nop, n_nop)
            chk_rd(`FRWS_OFF_CONTROL, i == 0 ? 32'hac : i == 1 ? 32'ha8 : 32'hec);
            ahb(1'b1, `FRWS_OFF_CONTROL, 8'h24);
        end
        $display("test refused triggers done");
        ahb(1'b1, `FRWS_OFF_ADDR_LOW, 8'h4f);
        ahb(1'b1, `FRWS_OFF_DATA_HIGH, 8'h0a);
        ahb(1'b1, `FRWS_OFF_DATA_LOW, 8'hbc);
        snap;
        unlock(8'h06);
        finish_op;
        `CHK("streamed words", b_wr + 16, n_wr)
        `CHK("program starts", b_prog + 1, n_prog)
        `CHK("erase on program", b_erase, n_erase)
        `CHK("row address", 10'h01a, flash_row_addr)
        `CHK("stall after done", 1'b0, cpu_stall)
        for (int i = 0; i < 16; i++) begin
            ex14 = i == 2 ? 14'h1234 : i == 3 ? 14'h2bcd : i == 15 ? 14'h0abc : `FRWS_BLANK;
            `CHK("latch word", ex14, got[i])
        end
        chk_rd(`FRWS_OFF_CONTROL, 32'h84);
        $display("test programming done");
        // rewriting a programmed row: erase it first, then reload and program
        snap;
        unlock(8'h16);
        finish_op;
        `CHK("erase starts", b_erase + 1, n_erase)
        `CHK("words on erase", b_wr, n_wr)
        chk_rd(`FRWS_OFF_CONTROL, 32'h84);
        unlock(8'h06);
        finish_op;
        `CHK("latch after commit", `FRWS_BLANK, got[2])
        `CHK("latch after commit", `FRWS_BLANK, got[3])
        `CHK("rewritten word", 14'h0abc, got[15])
        $display("test erase done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd(`FRWS_OFF_ADDR_LOW, 32'h00);
        $display("test second reset done");
        end_sim;
    end
endmodule

bind frws_sequencer frws_checker frws_checker_i (
    .hclk(hclk), .hresetn(hresetn), .flash_done(flash_done),
    .flash_row_addr(flash_row_addr), .flash_wr_en(flash_wr_en),
    .flash_wr_idx(flash_wr_idx), .flash_prog_start(flash_prog_start),
    .flash_erase_start(flash_erase_start), .cpu_nop(cpu_nop), .cpu_stall(cpu_stall)
);
